// *** rtl/led_on_time_defines.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the on-time bank
// Assumes: 100 MHz ref_clk
// Notes: included by bare name
`ifndef LED_ON_TIME_DEFINES_SVH
`define LED_ON_TIME_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CH2_UPPER 8'h06
`define OFS_CH2_MIDDLE 8'h07
`define OFS_CH3_UPPER 8'h08
`define OFS_CH3_MIDDLE 8'h09
`define OFS_CH4_UPPER 8'h0a
`define OFS_CH4_MIDDLE 8'h0b
`define OFS_LOW_BITS 8'h0c
`define OFS_CH5_UPPER 8'h0d

// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define RST_ON_TIME_BYTE 8'h7f
`define RST_CH5_UPPER 8'hff
`define RST_LOW_BITS 8'hff
`define CH5_LOW_FIXED 10'h3ff
`define LOW_CH1_POS 0
`define LOW_CH2_POS 2
`define LOW_CH3_POS 4
`define LOW_CH4_POS 6
`define UPPER_MSB 17
`define UPPER_LSB 10
`define MIDDLE_MSB 9
`define MIDDLE_LSB 2

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define STEP_NS 50
`define STEP_CYCLES ((`STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PERIOD_STEPS 18'h3_ffff

`endif

// *** rtl/led_on_time_pkg.sv ***
// Purpose: shared types of the on-time bank
// Assumes: nothing
// Notes: constants live in the defines header
package led_on_time_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [17:0] on_time_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_RECV = 3'b010,
    ST_ACK = 3'b011,
    ST_READ = 3'b100,
    ST_RACK = 3'b101
  } serial_state_e;
endpackage

// *** rtl/i2c_reg_port.sv ***
// Purpose: two-wire slave that reads and writes the byte registers
// Assumes: scl and sda arrive asynchronously; slave never stretches the clock
// Notes: first data byte after the address sets the pointer, which then increments
`timescale 1ns/1ns
module i2c_reg_port #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_n,
  output logic wr_stb,
  output led_on_time_pkg::reg_byte_t wr_addr,
  output led_on_time_pkg::reg_byte_t wr_data,
  output led_on_time_pkg::reg_byte_t rd_addr,
  input wire led_on_time_pkg::reg_byte_t rd_data
);
  import led_on_time_pkg::*;

  serial_state_e state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  reg_byte_t sh_r, sh_nxt, ptr_r, ptr_nxt, tx_r, tx_nxt, wd_r, wd_nxt, wa_r, wa_nxt;
  logic have_ptr_r, have_ptr_nxt, rw_r, rw_nxt, oe_n_r, oe_n_nxt, stb_r, stb_nxt, mack_r, mack_nxt;
  logic [2:0] scl_s_r, scl_s_nxt, sda_s_r, sda_s_nxt;
  logic scl_f_r, scl_f_nxt, sda_f_r, sda_f_nxt;
  logic scl_rise, scl_fall, start_c, stop_c;

  // ----------------------------------------
  // next state: filtering, framing, byte engine
  // ----------------------------------------
  always_comb begin
    scl_s_nxt = {scl_s_r[1:0], scl_in};
    sda_s_nxt = {sda_s_r[1:0], sda_in};
    // a level only counts once the second and third stages agree
    scl_f_nxt = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
    sda_f_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
    scl_rise = scl_f_nxt & ~scl_f_r;
    scl_fall = ~scl_f_nxt & scl_f_r;
    start_c = scl_f_r & scl_f_nxt & sda_f_r & ~sda_f_nxt;
    stop_c = scl_f_r & scl_f_nxt & ~sda_f_r & sda_f_nxt;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    tx_nxt = tx_r;
    wd_nxt = wd_r;
    wa_nxt = wa_r;
    have_ptr_nxt = have_ptr_r;
    rw_nxt = rw_r;
    oe_n_nxt = oe_n_r;
    stb_nxt = 1'b0;
    mack_nxt = mack_r;
    if (start_c) begin
      state_nxt = ST_ADDR;
      cnt_nxt = 4'h0;
      have_ptr_nxt = 1'b0;
      oe_n_nxt = 1'b1;
    end else if (stop_c) begin
      state_nxt = ST_IDLE;
      oe_n_nxt = 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
        end
        ST_ADDR, ST_RECV: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_f_nxt};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == 4'h8) begin
            if (state_r == ST_ADDR) begin
              if (sh_r[7:1] == DEV_ADDR) begin
                state_nxt = ST_ACK;
                oe_n_nxt = 1'b0;
                rw_nxt = sh_r[0];
              end else begin
                state_nxt = ST_IDLE;
              end
            end else begin
              state_nxt = ST_ACK;
              oe_n_nxt = 1'b0;
              rw_nxt = 1'b0;
              if (!have_ptr_r) begin
                ptr_nxt = sh_r;
                have_ptr_nxt = 1'b1;
              end else begin
                stb_nxt = 1'b1;
                wa_nxt = ptr_r;
                wd_nxt = sh_r;
                ptr_nxt = ptr_r + 8'h01;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            cnt_nxt = 4'h0;
            if (rw_r) begin
              state_nxt = ST_READ;
              tx_nxt = rd_data;
              oe_n_nxt = rd_data[7];
            end else begin
              state_nxt = ST_RECV;
              oe_n_nxt = 1'b1;
            end
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            if (cnt_r == 4'h7) begin
              state_nxt = ST_RACK;
              oe_n_nxt = 1'b1;
              ptr_nxt = ptr_r + 8'h01;
            end else begin
              tx_nxt = {tx_r[6:0], 1'b0};
              oe_n_nxt = tx_r[6];
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            mack_nxt = ~sda_f_nxt;
          end else if (scl_fall) begin
            // a nack from the master ends the read burst
            if (mack_r) begin
              state_nxt = ST_READ;
              tx_nxt = rd_data;
              oe_n_nxt = rd_data[7];
              cnt_nxt = 4'h0;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      tx_r <= 8'h00;
      wd_r <= 8'h00;
      wa_r <= 8'h00;
      have_ptr_r <= 1'b0;
      rw_r <= 1'b0;
      oe_n_r <= 1'b1;
      stb_r <= 1'b0;
      mack_r <= 1'b0;
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      tx_r <= tx_nxt;
      wd_r <= wd_nxt;
      wa_r <= wa_nxt;
      have_ptr_r <= have_ptr_nxt;
      rw_r <= rw_nxt;
      oe_n_r <= oe_n_nxt;
      stb_r <= stb_nxt;
      mack_r <= mack_nxt;
      scl_s_r <= scl_s_nxt;
      sda_s_r <= sda_s_nxt;
      scl_f_r <= scl_f_nxt;
      sda_f_r <= sda_f_nxt;
    end
  end

  assign sda_oe_n = oe_n_r;
  assign wr_stb = stb_r;
  assign wr_addr = wa_r;
  assign wr_data = wd_r;
  assign rd_addr = ptr_r;
endmodule

// *** rtl/led_string_on_time_regs.sv ***
// Purpose: on-time registers of strings 2 to 5 and their dimming outputs
// Assumes: 100 MHz ref_clk; dim pin asynchronous; external_dim_select from logic on ref_clk
// Notes: ch5 lower bits live elsewhere and are held at their reset value here
`timescale 1ns/1ns
`include "led_on_time_defines.svh"
module led_string_on_time_regs #(
  parameter logic [17:0] PERIOD_STEPS = `PERIOD_STEPS,
  parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic dim_in,
  input wire logic external_dim_select,
  output logic [3:0] led_on,
  output logic [1:0] ch1_low_bits,
  output led_on_time_pkg::on_time_t ch2_on_time
);
  import led_on_time_pkg::*;

  localparam int STEP_CYC = `STEP_CYCLES;
  localparam logic [2:0] PRE_LAST = 3'(STEP_CYC - 1);

  reg_byte_t upper_r [4];
  reg_byte_t upper_nxt [4];
  reg_byte_t middle_r [3];
  reg_byte_t middle_nxt [3];
  reg_byte_t low_r, low_nxt;
  logic wr_stb;
  reg_byte_t wr_addr, wr_data, rd_addr, rd_data;
  on_time_t ch_val [4];
  logic [2:0] dim_s_r, dim_s_nxt;
  logic dim_f_r, dim_f_nxt;
  logic [2:0] pre_r, pre_nxt;
  logic tick;
  on_time_t step_r, step_nxt;
  logic [3:0] led_r, led_nxt;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic on_time_t assemble(input reg_byte_t up, input reg_byte_t mid, input logic [1:0] lo);
    assemble = {up, mid, lo};
  endfunction

  function automatic reg_byte_t reg_read(input reg_byte_t a, input reg_byte_t up [4], input reg_byte_t mid [3],
                                         input reg_byte_t lo);
    unique case (a)
      `OFS_CH2_UPPER: reg_read = up[0];
      `OFS_CH2_MIDDLE: reg_read = mid[0];
      `OFS_CH3_UPPER: reg_read = up[1];
      `OFS_CH3_MIDDLE: reg_read = mid[1];
      `OFS_CH4_UPPER: reg_read = up[2];
      `OFS_CH4_MIDDLE: reg_read = mid[2];
      `OFS_LOW_BITS: reg_read = lo;
      `OFS_CH5_UPPER: reg_read = up[3];
      default: reg_read = 8'h00; // unmapped reads return zero
    endcase
  endfunction

  // ----------------------------------------
  // serial register port
  // ----------------------------------------
  i2c_reg_port #(.DEV_ADDR(DEV_ADDR)) u_port (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_n(sda_oe_n),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  assign sda_out = 1'b0; // open drain: only ever pulls low
  assign rd_data = reg_read(rd_addr, upper_r, middle_r, low_r);

  // ----------------------------------------
  // register writes; unmapped offsets are ignored
  // ----------------------------------------
  always_comb begin
    upper_nxt = upper_r;
    middle_nxt = middle_r;
    low_nxt = low_r;
    if (wr_stb) begin
      unique case (wr_addr)
        `OFS_CH2_UPPER: upper_nxt[0] = wr_data;
        `OFS_CH2_MIDDLE: middle_nxt[0] = wr_data;
        `OFS_CH3_UPPER: upper_nxt[1] = wr_data;
        `OFS_CH3_MIDDLE: middle_nxt[1] = wr_data;
        `OFS_CH4_UPPER: upper_nxt[2] = wr_data;
        `OFS_CH4_MIDDLE: middle_nxt[2] = wr_data;
        `OFS_LOW_BITS: low_nxt = wr_data;
        `OFS_CH5_UPPER: upper_nxt[3] = wr_data;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      upper_r[0] <= `RST_ON_TIME_BYTE;
      upper_r[1] <= `RST_ON_TIME_BYTE;
      upper_r[2] <= `RST_ON_TIME_BYTE;
      upper_r[3] <= `RST_CH5_UPPER;
      middle_r[0] <= `RST_ON_TIME_BYTE;
      middle_r[1] <= `RST_ON_TIME_BYTE;
      middle_r[2] <= `RST_ON_TIME_BYTE;
      low_r <= `RST_LOW_BITS;
    end else begin
      upper_r <= upper_nxt;
      middle_r <= middle_nxt;
      low_r <= low_nxt;
    end
  end

  // ----------------------------------------
  // value assembly from the three register parts; ch5 from its upper byte and fixed low bits
  // ----------------------------------------
  assign ch_val[0] = assemble(upper_r[0], middle_r[0], low_r[`LOW_CH2_POS +: 2]);
  assign ch_val[1] = assemble(upper_r[1], middle_r[1], low_r[`LOW_CH3_POS +: 2]);
  assign ch_val[2] = assemble(upper_r[2], middle_r[2], low_r[`LOW_CH4_POS +: 2]);
  assign ch_val[3] = {upper_r[3], `CH5_LOW_FIXED};
  assign ch1_low_bits = low_r[`LOW_CH1_POS +: 2];
  assign ch2_on_time = ch_val[0];

  // ----------------------------------------
  // step timebase, dim pin filter and led drive
  // ----------------------------------------
  // a value at or above the period length keeps the string on all period
  always_comb begin
    dim_s_nxt = {dim_s_r[1:0], dim_in};
    dim_f_nxt = (dim_s_r[1] == dim_s_r[2]) ? dim_s_r[2] : dim_f_r;
    tick = (pre_r == PRE_LAST);
    pre_nxt = tick ? 3'h0 : pre_r + 3'h1;
    step_nxt = step_r;
    if (tick) begin
      step_nxt = (step_r == PERIOD_STEPS - 18'h0_0001) ? 18'h0_0000 : step_r + 18'h0_0001;
    end
    for (int i = 0; i < 4; i++) begin
      led_nxt[i] = external_dim_select ? dim_f_r : (step_r < ch_val[i]);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dim_s_r <= 3'h0;
      dim_f_r <= 1'b0;
      pre_r <= 3'h0;
      step_r <= 18'h0_0000;
      led_r <= 4'h0;
    end else begin
      dim_s_r <= dim_s_nxt;
      dim_f_r <= dim_f_nxt;
      pre_r <= pre_nxt;
      step_r <= step_nxt;
      led_r <= led_nxt;
    end
  end

  assign led_on = led_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  logic cmp0;
  assign cmp0 = step_r < ch_val[0];

  sequence quiet_steps;
    !tick [*4] ##1 tick;
  endsequence

  sequence low_write;
    wr_stb && wr_addr == `OFS_LOW_BITS;
  endsequence

  step_tick_spacing_a: assert property (tick |=> quiet_steps)
    else $error("step tick not every 5 cycles");
  step_count_a: assert property (tick && step_r != PERIOD_STEPS - 18'h0_0001 |=>
    step_r == $past(step_r) + 18'h0_0001)
    else $error("step counter did not advance");
  upper_write_a: assert property (wr_stb && wr_addr == `OFS_CH2_UPPER |=> ch_val[0][17:10] == $past(wr_data))
    else $error("upper byte not in bits 17:10");
  middle_write_a: assert property (wr_stb && wr_addr == `OFS_CH3_MIDDLE |=> ch_val[1][9:2] == $past(wr_data))
    else $error("middle byte not in bits 9:2");
  low_split_a: assert property (low_write |=> ch_val[2][1:0] == $past(wr_data[7:6]) &&
    ch1_low_bits == $past(wr_data[1:0]))
    else $error("low bits mapped to wrong channel");
  low_shared_a: assert property (low_write |=> ch_val[0][1:0] == $past(wr_data[3:2]) && $stable(upper_r[0]))
    else $error("shared low register disturbed upper bits");
  ext_dim_a: assert property (external_dim_select |=> led_on == {4{$past(dim_f_r)}})
    else $error("leds do not follow dim pin");
  pwm_on_a: assert property (!external_dim_select |=> led_on[0] == $past(cmp0))
    else $error("ch2 led not on for programmed steps");

  // the step counter only moves on a tick, so an on-time can neither stretch nor shrink
  step_hold_a: assert property (!tick |=> $stable(step_r))
    else $error("step counter moved between ticks");
  // the wrap to step zero is what starts the next dimming period
  step_wrap_a: assert property (tick && step_r == PERIOD_STEPS - 18'h0_0001 |=> step_r == 18'h0_0000)
    else $error("step counter did not wrap at period end");
  // a second channel guards against a write decoder that only serves ch2
  ch4_upper_a: assert property (wr_stb && wr_addr == `OFS_CH4_UPPER |=> ch_val[2][17:10] == $past(wr_data))
    else $error("ch4 upper byte not in bits 17:10");
endmodule

// *** bench/i2c_host_model.sv ***
// Purpose: two-wire host that frames starts, stops and bytes toward the on-time bank
// Assumes: released sda is pulled up by the bench; the slave never stretches the clock
// Notes: lines move only just after a ref_clk edge; scl high and low each last well over 8 cycles
`timescale 1ns/1ns
module i2c_host_model #(
  parameter int HALF = 10
) (
  input wire logic ref_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  // ----------------------------------------
  // line control
  // ----------------------------------------
  // idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // both lines change together, right after an edge
  task automatic drive(input logic c, input logic low);
    @(posedge ref_clk);
    scl <= c;
    sda_low <= low;
  endtask

  // also serves as repeated start: sda is released while scl is still low
  task automatic start_cond();
    drive(1'b0, 1'b0);
    hold(HALF);
    drive(1'b1, 1'b0);
    hold(HALF);
    drive(1'b1, 1'b1);
    hold(HALF);
    drive(1'b0, 1'b1);
    hold(HALF);
  endtask

  task automatic stop_cond();
    drive(1'b0, 1'b1);
    hold(HALF);
    drive(1'b1, 1'b1);
    hold(HALF);
    drive(1'b1, 1'b0);
    hold(HALF);
  endtask

  // sda moves mid-low so the slave's filtered scl fall is never raced
  task automatic clock_bit(input logic b, output logic seen);
    hold(HALF / 2);
    drive(1'b0, ~b);
    hold(HALF / 2);
    drive(1'b1, ~b);
    hold(HALF / 2);
    seen = sda_line;
    hold(HALF / 2);
    drive(1'b0, ~b);
  endtask

  // msb first; ack is low when the slave answered
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic unused;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], unused);
    end
    clock_bit(1'b1, ack);
  endtask

  // last high ends the read with a nack
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic unused;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, b[i]);
    end
    clock_bit(last, unused);
  endtask
endmodule

// *** bench/tb_top.sv ***
// Purpose: self-checking bench of the on-time register bank and its dimming outputs
// Assumes: period shortened to 32 steps, 5 cycles a step
// Notes: register rows run in one loop; dimming, wrong address and reset are hand-written
`timescale 1ns/1ns
`define CHK(what, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
    end \
  end
module tb_top;
  import led_on_time_pkg::*;
  localparam logic [6:0] DEV = 7'h2a; // arbitrary value
  localparam reg_byte_t ROW_OFS [9] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h20};
  localparam reg_byte_t ROW_RST [9] = '{8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'hff, 8'hff, 8'h00};
  localparam reg_byte_t ROW_WR [9] = '{8'ha5, 8'h3c, 8'h11, 8'h22, 8'h33, 8'h44, 8'h9c, 8'h01, 8'h55};
  localparam int EXP_ON [4] = '{30, 0, 5, 160};
  logic ref_clk = 1'b0;
  logic resetn;
  logic dim_in;
  logic external_dim_select;
  logic scl;
  logic sda_low;
  logic sda_line;
  logic sda_oe_n;
  logic sda_out;
  logic [3:0] led_on;
  logic [1:0] ch1_low_bits;
  on_time_t ch2_on_time;
  int fail_count = 0;
  int check_count = 0;
  int cnt [4];
  reg_byte_t wr [8];
  reg_byte_t rd;
  logic nak;

  // ----------------------------------------
  // clock, wiring and instances
  // ----------------------------------------
  always #5 ref_clk = ~ref_clk;
  // open-drain sda with pull-up: low if either side pulls
  assign sda_line = (sda_low || !sda_oe_n) ? 1'b0 : 1'b1;

  i2c_host_model i2c_host_model_inst (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  led_string_on_time_regs #(.PERIOD_STEPS(18'h0_0020), .DEV_ADDR(DEV)) led_string_on_time_regs_inst (
    .ref_clk(ref_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .dim_in(dim_in), .external_dim_select(external_dim_select), .led_on(led_on),
    .ch1_low_bits(ch1_low_bits), .ch2_on_time(ch2_on_time));

  // ----------------------------------------
  // bus tasks and verdict
  // ----------------------------------------
  // nak collects every missing ack of the transfer
  task automatic reg_write(input logic [6:0] dev, input reg_byte_t ptr, input reg_byte_t d [8], input int n,
                           output logic nak);
    logic a;
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.send_byte({dev, 1'b0}, nak);
    i2c_host_model_inst.send_byte(ptr, a);
    nak = nak | a;
    for (int i = 0; i < n; i++) begin
      i2c_host_model_inst.send_byte(d[i], a);
      nak = nak | a;
    end
    i2c_host_model_inst.stop_cond();
  endtask

  task automatic reg_read(input reg_byte_t ptr, output reg_byte_t v);
    logic a;
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.send_byte({DEV, 1'b0}, a);
    i2c_host_model_inst.send_byte(ptr, a);
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.send_byte({DEV, 1'b1}, a);
    i2c_host_model_inst.recv_byte(1'b1, v);
    i2c_host_model_inst.stop_cond();
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // a hang anywhere counts as a mismatch
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    $display("timeout reached");
    close_out();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    dim_in = 1'b0;
    external_dim_select = 1'b0;
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("ch2_on_time", 18'h1_fdff, ch2_on_time)
    `CHK("ch1_low_bits", 2'b11, ch1_low_bits)
    `CHK("led_on", 4'h0, led_on)
    `CHK("sda_oe_n", 1'b1, sda_oe_n)
    `CHK("sda_out", 1'b0, sda_out)
    $display("test reset values done");
    @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // each row: reset value, write, readback; the last row is unmapped
    for (int r = 0; r < 9; r++) begin
      reg_read(ROW_OFS[r], rd);
      `CHK("reset value", ROW_RST[r], rd)
      wr[0] = ROW_WR[r];
      reg_write(DEV, ROW_OFS[r], wr, 1, nak);
      reg_read(ROW_OFS[r], rd);
      `CHK("readback", (ROW_OFS[r] > 8'h0d) ? 8'h00 : ROW_WR[r], rd)
    end
    `CHK("ch2_on_time", {8'ha5, 8'h3c, 2'b11}, ch2_on_time)
    `CHK("ch1_low_bits", 2'b00, ch1_low_bits)
    $display("test register rows done");
    // burst through 0x06..0x0d: ch2=6, ch3=0, ch4=1, ch5=0x3ff steps
    wr = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h4b, 8'h00};
    reg_write(DEV, 8'h06, wr, 8, nak);
    `CHK("burst ack", 1'b0, nak)
    `CHK("ch2_on_time", 18'h0_0006, ch2_on_time)
    cnt = '{default: 0};
    // any window of one whole period sees exactly value times 5 cycles on, or all 160 cycles for ch5, whose value exceeds the period
    repeat (160) begin
      @(negedge ref_clk);
      for (int i = 0; i < 4; i++) begin
        if (led_on[i] === 1'b1)
          cnt[i]++;
      end
    end
    for (int i = 0; i < 4; i++) begin
      `CHK("led on cycles", EXP_ON[i], cnt[i])
    end
    $display("test dimming done");
    // a master ack keeps the read burst going on the next register
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.send_byte({DEV, 1'b0}, nak);
    i2c_host_model_inst.send_byte(8'h0b, nak);
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.send_byte({DEV, 1'b1}, nak);
    i2c_host_model_inst.recv_byte(1'b0, rd);
    `CHK("burst read first", 8'h00, rd)
    i2c_host_model_inst.recv_byte(1'b1, rd);
    `CHK("burst read second", 8'h4b, rd)
    i2c_host_model_inst.stop_cond();
    $display("test read burst done");
    @(posedge ref_clk);
    external_dim_select <= 1'b1;
    dim_in <= 1'b1;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("led_on from pin", 4'hf, led_on)
    @(posedge ref_clk);
    dim_in <= 1'b0;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("led_on from pin", 4'h0, led_on)
    @(posedge ref_clk);
    external_dim_select <= 1'b0;
    $display("test dim pin done");
    wr[0] = 8'h11;
    reg_write(DEV + 7'h01, 8'h06, wr, 1, nak);
    `CHK("foreign address ack", 1'b1, nak)
    `CHK("ch2_on_time", 18'h0_0006, ch2_on_time)
    $display("test wrong address done");
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("ch2_on_time", 18'h1_fdff, ch2_on_time)
    `CHK("led_on", 4'h0, led_on)
    `CHK("sda_oe_n", 1'b1, sda_oe_n)
    @(posedge ref_clk);
    resetn <= 1'b1;
    // reset values all exceed the shortened period, so every string is on from the start
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("led_on after reset", 4'hf, led_on)
    repeat (4) @(posedge ref_clk);
    reg_read(8'h0c, rd);
    `CHK("low bits after reset", 8'hff, rd)
    $display("test second reset done");
    close_out();
  end
endmodule
